// >>> include/fsp_defines.svh
// Purpose: Opcodes, bit positions and reset values of the status block.
// Assumes: Included by the package and by every design file that needs it.
// Notes: Definitions only.
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

// Instruction opcodes seen on the serial link.
`define FSP_OP_RD_SR1 8'h05
`define FSP_OP_RD_SR2 8'h35
`define FSP_OP_RD_SR3 8'h15
`define FSP_OP_WR_SR1 8'h01
`define FSP_OP_WR_SR2 8'h31
`define FSP_OP_WR_SR3 8'h11
`define FSP_OP_WEN 8'h06
`define FSP_OP_WDI 8'h04
`define FSP_OP_SUSPEND 8'h75
`define FSP_OP_RESUME 8'h7a
`define FSP_OP_PREFIX_A 8'haa
`define FSP_OP_PREFIX_B 8'h55
`define FSP_OP_SEC_ERASE 8'h44
`define FSP_OP_SEC_PROG 8'h42

// Frame geometry: counter width in bits, limits in link clock edges, address frame length in bytes.
`define FSP_LEN_W 6
`define FSP_LEN_MAX 6'h3f
`define FSP_OP_LAST 6'h07
`define FSP_ADDR_BYTES 3'h4

// Status register one field positions.
`define FSP_S1_WEL 1
`define FSP_S1_BP_LO 2
`define FSP_S1_TB 5
`define FSP_S1_SEC 6
`define FSP_S1_SRP 7

// Status register two field positions.
`define FSP_S2_SRL 0
`define FSP_S2_QE 1
`define FSP_S2_LB_LO 3
`define FSP_S2_CMP 6

// Status register three field positions.
`define FSP_S3_WPS 2
`define FSP_S3_DRV_LO 5
`define FSP_S3_DRV_HI 6

// Reset values and the block lock count.
`define FSP_BP_RST 3'h0
`define FSP_DRV_RST 2'h3
`define FSP_BLK_LOCKS 62
`endif

// >>> include/fsp_pkg.sv
// Purpose: Shared types of the status and protection block.
// Assumes: Constants come from the defines header.
// Notes: Types only.
`include "fsp_defines.svh"

package fsp_pkg;

  // One captured frame: opcode, three address or data bytes, length.
  typedef struct packed {
    logic [7:0] op;
    logic [23:0] dat;
    logic [`FSP_LEN_W-1:0] len;
  } fsp_frame_t;

  // The three readable status bytes.
  typedef struct packed {
    logic [7:0] sr1;
    logic [7:0] sr2;
    logic [7:0] sr3;
  } fsp_status_t;

  // Array protection settings handed to the array controller.
  typedef struct packed {
    logic use_block_locks;
    logic invert_region;
    logic sector_granularity_bit;
    logic top_bottom_select;
    logic [2:0] block_protect;
  } fsp_prot_t;

endpackage

// >>> core/fsp_spi_link.sv
// Purpose: Link clock side: shifts in a frame and shifts out status.
// Assumes: Mode 0 serial link, chip select high between frames.
// Notes: Status bytes are stable while a frame runs.
`timescale 1ns/1ps
`include "fsp_defines.svh"

module fsp_spi_link (
  input wire logic i_link_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  input wire fsp_pkg::fsp_status_t i_status,
  output fsp_pkg::fsp_frame_t o_frame,
  output logic o_miso,
  output logic o_miso_oe_n
);
  import fsp_pkg::*;

  logic [`FSP_LEN_W-1:0] cnt_reg;
  logic [6:0] sh_reg;
  logic drive_reg;
  logic bit_reg;
  fsp_frame_t frame_reg;
  wire [`FSP_LEN_W-1:0] cnt_next;
  wire [7:0] byte_in;
  wire [2:0] byte_idx;
  wire byte_done;
  wire is_read;
  wire [7:0] rd_byte;

  // Bit counting saturates so long frames keep a defined length.
  assign cnt_next = (cnt_reg == `FSP_LEN_MAX) ? cnt_reg :
                    cnt_reg + `FSP_LEN_W'(1);
  assign byte_in = {sh_reg, i_mosi};
  assign byte_idx = cnt_reg[5:3];
  assign byte_done = (cnt_reg[2:0] == 3'h7);
  assign is_read = (frame_reg.op == `FSP_OP_RD_SR1) |
                   (frame_reg.op == `FSP_OP_RD_SR2) |
                   (frame_reg.op == `FSP_OP_RD_SR3);
  assign rd_byte = (frame_reg.op == `FSP_OP_RD_SR1) ? i_status.sr1 :
                   (frame_reg.op == `FSP_OP_RD_SR2) ? i_status.sr2 :
                   i_status.sr3;

  // The clock stands still outside frames, so chip select clears the count.
  always_ff @(posedge i_link_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // Frame capture; it holds after the frame for the core to read.
  always_ff @(posedge i_link_sclk) begin
    sh_reg <= byte_in[6:0];
    frame_reg.len <= cnt_next;
    if (cnt_reg == `FSP_OP_LAST) begin
      frame_reg.op <= byte_in;
    end
    if (byte_done && byte_idx == 3'h1) begin
      frame_reg.dat[23:16] <= byte_in;
    end
    if (byte_done && byte_idx == 3'h2) begin
      frame_reg.dat[15:8] <= byte_in;
    end
    if (byte_done && byte_idx == 3'h3) begin
      frame_reg.dat[7:0] <= byte_in;
    end
  end

  // Read data changes on the falling edge, most significant bit first.
  always_ff @(negedge i_link_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      drive_reg <= 1'b0;
      bit_reg <= 1'b0;
    end else begin
      drive_reg <= is_read & (byte_idx != 3'h0);
      bit_reg <= rd_byte[~cnt_reg[2:0]];
    end
  end

  assign o_frame = frame_reg;
  assign o_miso = bit_reg;
  assign o_miso_oe_n = ~drive_reg;
endmodule

// >>> core/fsp_status_core.sv
// Purpose: Status and configuration registers of a serial flash.
// Assumes: Frames end with chip select high; the core clock runs free.
// Notes: One-time bits come from fuses sampled after reset release.
`timescale 1ns/1ps
`include "fsp_defines.svh"

// How it works
// - Status writes gated by select bits, latch, pin.
// - Both select bits zero: latch alone allows write.
// - Select set, pin low: status write rejected outside quad transfers.
// - Select set, pin high: latch allows write.
// - Lock bit rejects writes; reset clears it.
// - Prefix pair then lock write locks forever.
// - Suspend flag set by suspend, cleared by resume.
// - Security locks load from fuses after reset, set individually.
// - Set security lock never clears, refuses program.
// - Quad bit zero keeps hold, no quad.
// - Quad bit one frees IO2, IO3, drops hold.
// - Scheme bit picks protect bits or block locks.
// - Block lock bits all one after reset.
// - Drive field selects strength, defaults to 25%.
// - Reserved bits read zero, writes ignored.
// - Three read instructions return three status bytes.
// - Latch set by enable, cleared by write.
// - Complement bit inverts the chosen region unless block locks are picked.
module fsp_status_core (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_link_sclk,
  input wire logic i_cs_n,
  input wire logic i_mosi,
  input wire logic i_wp_n,
  input wire logic i_quad_active,
  input wire logic i_otp_fuse,
  input wire logic [2:0] i_lb_fuse,
  output logic o_miso,
  output logic o_miso_oe_n,
  output fsp_pkg::fsp_status_t o_status,
  output fsp_pkg::fsp_prot_t o_prot,
  output logic [`FSP_BLK_LOCKS-1:0] o_block_locks,
  output logic [1:0] o_drive_strength,
  output logic o_quad_enable,
  output logic o_hold_enable,
  output logic [2:0] o_security_locks,
  output logic o_otp_burn,
  output logic o_secreg_go,
  output logic o_secreg_refused,
  output logic o_write_refused
);
  import fsp_pkg::*;

  // Pin synchronisers and frame end detection.
  logic cs_meta_reg;
  logic cs_sync_reg;
  logic cs_prev_reg;
  logic wp_meta_reg;
  logic wp_sync_reg;

  // Status fields.
  logic wel_reg;
  logic [2:0] bp_reg;
  logic tb_reg;
  logic sec_reg;
  logic srp_reg;
  logic srl_reg;
  logic qe_reg;
  logic [2:0] lb_reg;
  logic cmp_reg;
  logic sus_reg;
  logic wps_reg;
  logic [1:0] drv_reg;
  logic otp_reg;
  logic [1:0] prefix_reg;
  logic loaded_reg;
  logic [`FSP_BLK_LOCKS-1:0] blk_reg;

  // Event pulses.
  logic burn_reg;
  logic go_reg;
  logic refused_reg;
  logic wr_refused_reg;

  fsp_frame_t frame;
  fsp_status_t status;

  // True when the captured frame is exactly the given byte count.
  function automatic logic fsp_is_len(input fsp_frame_t f,
                                      input logic [2:0] n);
    fsp_is_len = (f.len[2:0] == 3'h0) && (f.len[5:3] == n);
  endfunction

  // True when the frame is a lone opcode of the given value.
  function automatic logic fsp_is_cmd(input fsp_frame_t f,
                                      input logic [7:0] op);
    fsp_is_cmd = fsp_is_len(f, 3'h1) && (f.op == op);
  endfunction

  // The link side captures the frame and serves status reads.
  fsp_spi_link u_link (
    .i_link_sclk(i_link_sclk),
    .i_cs_n(i_cs_n),
    .i_mosi(i_mosi),
    .i_status(status),
    .o_frame(frame),
    .o_miso(o_miso),
    .o_miso_oe_n(o_miso_oe_n)
  );

  // Chip select and write protect come from pins: two flops each.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
      wp_meta_reg <= 1'b0;
      wp_sync_reg <= 1'b0;
    end else begin
      cs_meta_reg <= i_cs_n;
      cs_sync_reg <= cs_meta_reg;
      cs_prev_reg <= cs_sync_reg;
      wp_meta_reg <= i_wp_n;
      wp_sync_reg <= wp_meta_reg;
    end
  end

  // The frame is read only once the link clock has stopped.
  wire frame_end = cs_sync_reg & ~cs_prev_reg;

  // Command decoding of the finished frame.
  wire cmd_wen = fsp_is_cmd(frame, `FSP_OP_WEN);
  wire cmd_wdi = fsp_is_cmd(frame, `FSP_OP_WDI);
  wire cmd_sus = fsp_is_cmd(frame, `FSP_OP_SUSPEND);
  wire cmd_res = fsp_is_cmd(frame, `FSP_OP_RESUME);
  wire cmd_pfa = fsp_is_cmd(frame, `FSP_OP_PREFIX_A);
  wire cmd_pfb = fsp_is_cmd(frame, `FSP_OP_PREFIX_B);
  wire len2 = fsp_is_len(frame, 3'h2);
  wire len3 = fsp_is_len(frame, 3'h3);
  wire op_w1 = frame.op == `FSP_OP_WR_SR1;
  wire op_w2 = frame.op == `FSP_OP_WR_SR2;
  wire op_w3 = frame.op == `FSP_OP_WR_SR3;
  wire [7:0] byte1 = frame.dat[23:16];
  wire [7:0] byte2 = frame.dat[15:8];

  // Which registers a write frame targets and with which byte.
  wire wr1 = op_w1 & (len2 | len3);
  wire wr2 = (op_w2 & len2) | (op_w1 & len3);
  wire wr3 = op_w3 & len2;
  wire [7:0] sr2_data = op_w1 ? byte2 : byte1;
  wire wr_any = wr1 | wr2 | wr3;

  // Hardware protection applies only outside quad transfers.
  wire hw_block = srp_reg & ~wp_sync_reg & ~i_quad_active;
  wire sw_ok = wel_reg & ~srl_reg & ~otp_reg;
  wire wr_ok = sw_ok & ~hw_block;
  wire accept = frame_end & wr_any & wr_ok;
  wire reject = frame_end & wr_any & ~wr_ok;

  // The permanent lock needs the prefix pair right before the write.
  wire new_srl = sr2_data[`FSP_S2_SRL];
  wire otp_set = accept & wr2 & new_srl & (prefix_reg == 2'h2);

  // Security register program or erase with its address decode.
  wire op_sec = (frame.op == `FSP_OP_SEC_ERASE) |
                (frame.op == `FSP_OP_SEC_PROG);
  wire sec_cmd = frame_end & op_sec & (frame.len[5:3] >= `FSP_ADDR_BYTES);
  wire [1:0] sec_sel = frame.dat[13:12];
  wire sec_locked = (sec_sel == 2'h0) | lb_reg[sec_sel - 2'h1];
  wire sec_go = sec_cmd & wel_reg & ~sec_locked;
  wire sec_refused = sec_cmd & (~wel_reg | sec_locked);

  // Next values of the write enable latch.
  wire wel_set = frame_end & cmd_wen;
  wire wel_clr = frame_end & cmd_wdi | accept | sec_go;
  wire wel_next = wel_set | (wel_reg & ~wel_clr);

  // Next values of status register one.
  wire [2:0] bp_next = (accept & wr1) ?
                       byte1[`FSP_S1_BP_LO +: 3] : bp_reg;
  wire tb_next = (accept & wr1) ? byte1[`FSP_S1_TB] : tb_reg;
  wire sec_next = (accept & wr1) ? byte1[`FSP_S1_SEC] : sec_reg;
  wire srp_next = (accept & wr1) ? byte1[`FSP_S1_SRP] : srp_reg;

  // Next values of status register two; lock bits only ever set.
  wire srl_next = (accept & wr2) ? new_srl : srl_reg;
  wire qe_next = (accept & wr2) ? sr2_data[`FSP_S2_QE] : qe_reg;
  wire [2:0] lb_wr = (accept & wr2) ?
                     sr2_data[`FSP_S2_LB_LO +: 3] : 3'h0;
  wire [2:0] lb_next = lb_reg | lb_wr;
  wire cmp_next = (accept & wr2) ? sr2_data[`FSP_S2_CMP] : cmp_reg;

  // Next values of status register three; reserved bits are dropped.
  wire wps_next = (accept & wr3) ? byte1[`FSP_S3_WPS] : wps_reg;
  wire [1:0] drv_next = (accept & wr3) ?
                        byte1[`FSP_S3_DRV_LO +: 2] : drv_reg;

  // Suspend flag; suspend and resume never share one frame.
  wire sus_next = (frame_end & cmd_sus) |
                  (sus_reg & ~(frame_end & cmd_res));

  // Prefix tracker: any other frame breaks the sequence.
  wire [1:0] prefix_next = ~frame_end ? prefix_reg :
                           cmd_pfa ? 2'h1 :
                           (cmd_pfb & prefix_reg == 2'h1) ? 2'h2 :
                           2'h0;

  // Write enable latch and suspend flag.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      wel_reg <= 1'b0;
      sus_reg <= 1'b0;
      prefix_reg <= 2'h0;
    end else begin
      wel_reg <= wel_next;
      sus_reg <= sus_next;
      prefix_reg <= prefix_next;
    end
  end

  // Status register one fields.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      bp_reg <= `FSP_BP_RST;
      tb_reg <= 1'b0;
      sec_reg <= 1'b0;
      srp_reg <= 1'b0;
    end else begin
      bp_reg <= bp_next;
      tb_reg <= tb_next;
      sec_reg <= sec_next;
      srp_reg <= srp_next;
    end
  end

  // Status register two and three fields.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      srl_reg <= 1'b0;
      qe_reg <= 1'b0;
      cmp_reg <= 1'b0;
      wps_reg <= 1'b0;
      drv_reg <= `FSP_DRV_RST;
    end else begin
      srl_reg <= srl_next;
      qe_reg <= qe_next;
      cmp_reg <= cmp_next;
      wps_reg <= wps_next;
      drv_reg <= drv_next;
    end
  end

  // One-time bits: loaded from the fuses in the first cycle after reset.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      loaded_reg <= 1'b0;
      lb_reg <= 3'h0;
      otp_reg <= 1'b0;
    end else if (!loaded_reg) begin
      loaded_reg <= 1'b1;
      lb_reg <= i_lb_fuse;
      otp_reg <= i_otp_fuse;
    end else begin
      lb_reg <= lb_next;
      otp_reg <= otp_reg | otp_set;
    end
  end

  // Individual block locks: each lock comes up set after reset.
  genvar gi;
  generate
    for (gi = 0; gi < `FSP_BLK_LOCKS; gi = gi + 1) begin : g_blk
      always_ff @(posedge i_core_clk) begin
        if (!i_nrst) begin
          blk_reg[gi] <= 1'b1;
        end else begin
          blk_reg[gi] <= blk_reg[gi];
        end
      end
    end
  endgenerate

  // Event pulses, one core cycle each.
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      burn_reg <= 1'b0;
      go_reg <= 1'b0;
      refused_reg <= 1'b0;
      wr_refused_reg <= 1'b0;
    end else begin
      burn_reg <= otp_set;
      go_reg <= sec_go;
      refused_reg <= sec_refused;
      wr_refused_reg <= reject;
    end
  end

  // Status bytes as read by the host; reserved bits read zero.
  assign status.sr1 = {srp_reg, sec_reg, tb_reg, bp_reg, wel_reg,
                       1'b0};
  assign status.sr2 = {sus_reg, cmp_reg, lb_reg, 1'b0, qe_reg,
                       srl_reg};
  assign status.sr3 = {1'b0, drv_reg, 2'h0, wps_reg, 2'h0};

  // Protection scheme handed to the array controller.
  assign o_prot.use_block_locks = wps_reg;
  assign o_prot.invert_region = cmp_reg & ~wps_reg;
  assign o_prot.sector_granularity_bit = sec_reg;
  assign o_prot.top_bottom_select = tb_reg;
  assign o_prot.block_protect = bp_reg;

  // Pin functions follow the quad enable bit.
  assign o_quad_enable = qe_reg;
  assign o_hold_enable = ~qe_reg;

  // Remaining outputs come straight from flops.
  assign o_status = status;
  assign o_block_locks = blk_reg;
  assign o_drive_strength = drv_reg;
  assign o_security_locks = lb_reg;
  assign o_otp_burn = burn_reg;
  assign o_secreg_go = go_reg;
  assign o_secreg_refused = refused_reg;
  assign o_write_refused = wr_refused_reg;
endmodule

// >>> dv/fsp_host_model.sv
// Purpose: Host side of the serial link issuing status instructions.
// Assumes: Mode 0, MSB first; the link clock runs only inside frames.
// Notes: Half period 3 ns, unrelated in phase to the core clock.
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fsp_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  // Idle link: clock low, chip select high. Chip select starts low for a
  // moment, so the link counter sees one rising edge and starts at zero.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b0;
    o_mosi = 1'b0;
    #5;
    o_cs_n = 1'b1;
  end

  // Sends n bits of d MSB first; q keeps the last eight bits of miso.
  task automatic xfer(input logic [31:0] d, input int n,
                      output logic [7:0] q);
    q = 8'h00;
    o_cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_mosi <= d[i];
      #3;
      q = {q[6:0], i_miso};
      o_sclk <= 1'b1;
      #3;
      o_sclk <= 1'b0;
    end
    #3;
    o_cs_n <= 1'b1;
    // A released data line does not keep its last level.
    o_mosi <= ~o_mosi;
    #300;
  endtask

  // The one-time lock prefix, two frames of their own.
  task automatic otp_prefix();
    logic [7:0] q;
    xfer({24'h0, `FSP_OP_PREFIX_A}, 8, q);
    xfer({24'h0, `FSP_OP_PREFIX_B}, 8, q);
  endtask
endmodule

// >>> dv/fsp_status_properties.sv
// Purpose: Port-level properties of the status block.
// Assumes: Bound to the core top; one clock domain is watched.
// Notes: Reserved bits are taken to read as zero.
`timescale 1ns/1ps
`include "fsp_defines.svh"
module fsp_status_props (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_wp_n,
  input wire logic i_quad_active,
  input wire fsp_pkg::fsp_status_t o_status,
  input wire fsp_pkg::fsp_prot_t o_prot,
  input wire logic [`FSP_BLK_LOCKS-1:0] o_block_locks,
  input wire logic [1:0] o_drive_strength,
  input wire logic o_quad_enable,
  input wire logic o_hold_enable,
  input wire logic [2:0] o_security_locks,
  input wire logic o_write_refused
);
  import fsp_pkg::*;
  // All checks share the core clock and its reset.
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);

  // Decoded outputs follow the status bits behind them.
  quad_hold_a: assert property (
    o_hold_enable != o_quad_enable && o_quad_enable == o_status.sr2[1])
    else $error("quad and hold disagree");
  drive_mirror_a: assert property (
    o_drive_strength == o_status.sr3[6:5])
    else $error("drive field mismatch");
  prot_mirror_a: assert property (
    o_prot == {o_status.sr3[2], o_status.sr2[6] & !o_status.sr3[2],
               o_status.sr1[6:2]})
    else $error("protection settings mismatch");
  blk_locked_a: assert property (&o_block_locks)
    else $error("block lock cleared");
  lock_mirror_a: assert property (
    o_security_locks == o_status.sr2[5:3])
    else $error("security locks mismatch");
  rsvd_zero_a: assert property (
    {o_status.sr1[0], o_status.sr2[2], o_status.sr3[7], o_status.sr3[4:3],
     o_status.sr3[1:0]} == 7'h00)
    else $error("reserved bit set");

  // Set security locks never clear.
  lock_sticky_a: assert property (
    ($past(o_security_locks) & ~o_security_locks) == 3'h0)
    else $error("security lock cleared");

  // A refused write leaves every status bit alone.
  frozen_a: assert property (
    o_write_refused |-> $stable(o_status) ##1 $stable(o_status))
    else $error("refused write changed status");

  // A change in bits 7:2 of status byte one or in byte three needs the latch and a clear lock bit, and ends the latch.
  write_gate_a: assert property (
    (o_status.sr1[7:2] != $past(o_status.sr1[7:2]) ||
     o_status.sr3 != $past(o_status.sr3)) |->
    $past(o_status.sr1[1]) && !$past(o_status.sr2[0]) && !o_status.sr1[1])
    else $error("status changed without permission");

  // Protect select with the pin held low outside quad transfers freezes the third byte.
  wp_hold_a: assert property (
    (o_status.sr1[7] && !i_wp_n && !i_quad_active) [*5] |=>
    $stable(o_status.sr3))
    else $error("write passed a low protect pin");
endmodule

bind fsp_status_core fsp_status_props chk_u (
  .i_core_clk(i_core_clk),
  .i_nrst(i_nrst),
  .i_wp_n(i_wp_n),
  .i_quad_active(i_quad_active),
  .o_status(o_status),
  .o_prot(o_prot),
  .o_block_locks(o_block_locks),
  .o_drive_strength(o_drive_strength),
  .o_quad_enable(o_quad_enable),
  .o_hold_enable(o_hold_enable),
  .o_security_locks(o_security_locks),
  .o_write_refused(o_write_refused)
);

// >>> dv/tb_flash_status_protect_config.sv
// Purpose: Self-checking bench of the status and protection block.
// Assumes: The host model drives the link; the bench drives pins, fuses.
// Notes: Output pulses are counted on the core clock.
`timescale 1ns/1ps
`include "fsp_defines.svh"
module tb_flash_status_protect_config;
  import fsp_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wp_n = 1'b1;
  logic fuse = 1'b0;
  logic [2:0] lbf = 3'h0;
  logic quad = 1'b0;
  logic sclk, cs_n, mosi, miso, oe_n, qe, hold, p_w, p_s, p_g, p_b;
  fsp_prot_t pr;
  logic [`FSP_BLK_LOCKS-1:0] blk;
  logic [1:0] drv;
  logic [2:0] lbs;
  logic [7:0] q;
  int err_count = 0;
  int n_checks = 0;
  int nw = 0;
  int ns = 0;
  int ng = 0;
  int nb = 0;
  int noe = 0;

  fsp_host_model host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi),
    .i_miso(miso));

  fsp_status_core dut_u (.i_core_clk(clk), .i_nrst(nrst),
    .i_link_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi), .i_wp_n(wp_n),
    .i_quad_active(quad), .i_otp_fuse(fuse), .i_lb_fuse(lbf),
    .o_miso(miso), .o_miso_oe_n(oe_n), .o_status(), .o_prot(pr),
    .o_block_locks(blk), .o_drive_strength(drv), .o_quad_enable(qe),
    .o_hold_enable(hold), .o_security_locks(lbs), .o_otp_burn(p_b),
    .o_secreg_go(p_g), .o_secreg_refused(p_s), .o_write_refused(p_w));

  // Core clock at 40 MHz.
  initial begin
    forever #12.5 clk = ~clk;
  end

  // Counts the one-cycle pulses.
  always @(posedge clk) begin
    nw <= nw + int'(p_w);
    ns <= ns + int'(p_s);
    ng <= ng + int'(p_g);
    nb <= nb + int'(p_b);
  end

  // Counts link clock edges at which read data is driven.
  always @(posedge sclk) begin
    if (!oe_n) begin
      noe <= noe + 1;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // A read drives data for exactly one byte and releases the line after.
  task automatic rd(input logic [7:0] op, input logic [7:0] exp);
    int n0;
    n0 = noe;
    host_u.xfer({16'h0, op, 8'h00}, 16, q);
    chk(q, exp);
    chk(8'(noe - n0), 8'h08);
    chk({7'h0, oe_n}, 8'h01);
  endtask

  task automatic cmd(input logic [7:0] op);
    host_u.xfer({24'h0, op}, 8, q);
  endtask

  task automatic wr(input logic [7:0] op, input logic [7:0] d);
    cmd(`FSP_OP_WEN);
    host_u.xfer({16'h0, op, d}, 16, q);
  endtask

  task automatic do_reset();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Main sequence of tests.
  initial begin
    do_reset();
    rd(`FSP_OP_RD_SR1, 8'h00);
    rd(`FSP_OP_RD_SR2, 8'h00);
    rd(`FSP_OP_RD_SR3, 8'h60);
    chk({7'h0, &blk}, 8'h01);
    host_u.xfer({16'h0, `FSP_OP_WR_SR3, 8'h00}, 16, q);
    rd(`FSP_OP_RD_SR3, 8'h60);
    chk(8'(nw), 8'h01);
    $display("test reset_and_latch done");
    for (int k = 3; k >= 0; k--) begin
      wr(`FSP_OP_WR_SR3, {1'b1, 2'(k), 2'h3, k[0], 2'h3});
      rd(`FSP_OP_RD_SR3, {1'b0, 2'(k), 2'h0, k[0], 2'h0});
      chk({6'h0, drv}, 8'(k));
      chk({7'h0, pr.use_block_locks}, {7'h0, k[0]});
    end
    cmd(`FSP_OP_WEN);
    rd(`FSP_OP_RD_SR1, 8'h02);
    cmd(`FSP_OP_WDI);
    rd(`FSP_OP_RD_SR1, 8'h00);
    host_u.xfer({23'h0, `FSP_OP_WEN, 1'b0}, 9, q);
    rd(`FSP_OP_RD_SR1, 8'h00);
    wr(`FSP_OP_WR_SR2, 8'h02);
    chk({6'h0, qe, hold}, 8'h02);
    wr(`FSP_OP_WR_SR2, 8'h00);
    chk({6'h0, qe, hold}, 8'h01);
    cmd(`FSP_OP_SUSPEND);
    rd(`FSP_OP_RD_SR2, 8'h80);
    cmd(`FSP_OP_RESUME);
    rd(`FSP_OP_RD_SR2, 8'h00);
    $display("test fields done");
    wr(`FSP_OP_WR_SR2, 8'h08);
    wr(`FSP_OP_WR_SR2, 8'h00);
    rd(`FSP_OP_RD_SR2, 8'h08);
    wr(`FSP_OP_WR_SR2, 8'h10);
    chk({5'h0, lbs}, 8'h03);
    cmd(`FSP_OP_WEN);
    host_u.xfer({`FSP_OP_SEC_ERASE, 24'h001000}, 32, q);
    chk(8'(ns), 8'h01);
    cmd(`FSP_OP_WEN);
    host_u.xfer({`FSP_OP_SEC_PROG, 24'h003000}, 32, q);
    chk(8'(ng), 8'h01);
    $display("test security_locks done");
    cmd(`FSP_OP_WEN);
    host_u.xfer({8'h0, `FSP_OP_WR_SR1, 8'h80, 8'h58}, 24, q);
    rd(`FSP_OP_RD_SR1, 8'h80);
    chk({7'h0, pr.invert_region}, 8'h01);
    @(posedge clk);
    wp_n <= 1'b0;
    wr(`FSP_OP_WR_SR3, 8'h20);
    rd(`FSP_OP_RD_SR3, 8'h00);
    @(posedge clk);
    quad <= 1'b1;
    wr(`FSP_OP_WR_SR3, 8'h40);
    rd(`FSP_OP_RD_SR3, 8'h40);
    @(posedge clk);
    quad <= 1'b0;
    wp_n <= 1'b1;
    wr(`FSP_OP_WR_SR3, 8'h20);
    rd(`FSP_OP_RD_SR3, 8'h20);
    wr(`FSP_OP_WR_SR2, 8'h59);
    wr(`FSP_OP_WR_SR3, 8'h00);
    rd(`FSP_OP_RD_SR3, 8'h20);
    chk(8'(nw), 8'h03);
    @(posedge clk);
    lbf <= 3'h3;
    do_reset();
    rd(`FSP_OP_RD_SR2, 8'h18);
    wr(`FSP_OP_WR_SR1, 8'h1c);
    rd(`FSP_OP_RD_SR1, 8'h1c);
    chk({5'h0, pr.block_protect}, 8'h07);
    $display("test protect_pin_and_lock done");
    cmd(`FSP_OP_WEN);
    host_u.otp_prefix();
    host_u.xfer({16'h0, `FSP_OP_WR_SR2, 8'h01}, 16, q);
    chk(8'(nb), 8'h01);
    rd(`FSP_OP_RD_SR2, 8'h19);
    @(posedge clk);
    fuse <= 1'b1;
    do_reset();
    wr(`FSP_OP_WR_SR3, 8'h00);
    rd(`FSP_OP_RD_SR3, 8'h60);
    $display("test permanent_lock done");
    complete_run();
  end

  // Cuts a hang short well after the tests should have finished.
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
endmodule
